//--- src/sewr_pkg.sv
package sewr_pkg;

  // word geometry of the serial memory
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 32;

  // command frame: start bit, read opcode, word address
  localparam logic START_BIT = 1'b1;
  localparam logic [1:0] OPCODE_READ = 2'h2;
  localparam int CMD_BITS = 1 + 2 + ADDR_W;
  // returned frame: one dummy zero then the data word
  localparam int READ_BITS = 1 + DATA_W;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CMD_LAST = CNT_W'(CMD_BITS - 1);
  localparam logic [CNT_W-1:0] READ_LAST = CNT_W'(READ_BITS - 1);
  // serial clock rises per frame
  localparam logic [5:0] FRAME_RISES = 6'(CMD_BITS + READ_BITS);

  // pins toward the memory, all driven by this block
  typedef struct packed {
    logic select;
    logic sclk;
    logic dataOut;
    logic dataOe;
  } sewr_pins_t;
  localparam sewr_pins_t PINS_IDLE = '{select: 1'b0, sclk: 1'b0, dataOut: 1'b0, dataOe: 1'b0};

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_SELECT,
    LS_CMD,
    LS_READ,
    LS_END
  } sewr_link_state_t;

endpackage

//--- src/sewr_word_reader.sv
`timescale 1ns/1ps

module sewr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [CW-1:0] count_r;
  logic outValid_r;
  logic [WIDTH-1:0] outData_r;
  logic push;
  logic pop;

  assign inReady = count_r < CW'(DEPTH);
  assign push = inValid && inReady;
  // output stage reloads when empty or being taken
  assign pop = (count_r != '0) && (!outValid_r || outReady);
  assign outValid = outValid_r;
  assign outData = outData_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
      end
      count_r <= count_r + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      outValid_r <= 1'b0;
      outData_r <= '0;
    end else if (pop) begin
      outValid_r <= 1'b1;
      outData_r <= mem[rdPtr_r];
    end else if (outReady) begin
      outValid_r <= 1'b0;
    end
  end

endmodule // sewr_fifo

module sewr_word_reader #(
  parameter int DEPTH = sewr_pkg::FIFO_DEPTH
) (
  // system clock and reset
  input wire logic clk,
  input wire logic srst,
  // link clock
  input wire logic linkClk,
  // read requests
  input wire logic reqValid,
  input wire logic [sewr_pkg::ADDR_W-1:0] reqAddr,
  output logic reqReady,
  // fetched words
  output logic wordValid,
  output logic [sewr_pkg::DATA_W-1:0] wordData,
  input wire logic wordReady,
  // serial memory pins
  output sewr_pkg::sewr_pins_t memPins,
  input wire logic memDataIn
);
  import sewr_pkg::*;

  // ---------------- system clock side ----------------
  logic reqReady_r;
  logic busy_r;
  logic busy_nxt;
  logic reqToggle_r;
  logic [ADDR_W-1:0] addrHold_r;
  logic doneS1_r;
  logic doneS2_r;
  logic doneSeen_r;
  logic accept;
  logic push;
  logic fifoInReady;

  // link side signals read across the crossing
  logic doneToggle_r;
  logic [DATA_W-1:0] dataHold_r;

  assign accept = reqValid && reqReady_r;
  assign push = doneS2_r != doneSeen_r;
  assign busy_nxt = accept ? 1'b1 : (push ? 1'b0 : busy_r);
  assign reqReady = reqReady_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      reqReady_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      // new command only once the previous word is home and has room
      reqReady_r <= !busy_nxt && fifoInReady && !push;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reqToggle_r <= 1'b0;
      addrHold_r <= '0;
    end else if (accept) begin
      reqToggle_r <= !reqToggle_r;
      addrHold_r <= reqAddr;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      doneS1_r <= 1'b0;
      doneS2_r <= 1'b0;
      doneSeen_r <= 1'b0;
    end else begin
      doneS1_r <= doneToggle_r;
      doneS2_r <= doneS1_r;
      doneSeen_r <= doneS2_r;
    end
  end

  sewr_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) wordFifo (
    .clk(clk),
    .srst(srst),
    .inValid(push),
    .inData(dataHold_r),
    .inReady(fifoInReady),
    .outValid(wordValid),
    .outData(wordData),
    .outReady(wordReady)
  );

  accept_holds_a: assert property (@(posedge clk) disable iff (srst)
    accept |=> !reqReady ##0 busy_r)
    else $error("request accepted while a read is still open");

  one_word_a: assert property (@(posedge clk) disable iff (srst)
    push |-> busy_r && !reqReady)
    else $error("word returned without an open request");

  // ---------------- link clock side ----------------
  logic rstS1_r;
  logic linkRst;
  logic reqS1_r;
  logic reqS2_r;
  logic reqSeen_r;
  logic dinS1_r;
  logic dinS2_r;
  sewr_link_state_t st_r;
  logic phase_r;
  logic [CNT_W-1:0] bitCnt_r;
  logic [CMD_BITS-1:0] cmdSh_r;
  logic [DATA_W-1:0] dataSh_r;
  sewr_pins_t pins_r;
  logic newReq;
  logic rise;
  logic fall;
  logic [5:0] riseCnt_r;

  assign newReq = (st_r == LS_IDLE) && (reqS2_r != reqSeen_r);
  assign rise = (st_r == LS_CMD || st_r == LS_READ) && !phase_r;
  assign fall = (st_r == LS_CMD || st_r == LS_READ) && phase_r;
  assign memPins = pins_r;

  always_ff @(posedge linkClk) begin
    rstS1_r <= srst;
    linkRst <= rstS1_r;
  end

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      reqS1_r <= 1'b0;
      reqS2_r <= 1'b0;
      dinS1_r <= 1'b0;
      dinS2_r <= 1'b0;
    end else begin
      reqS1_r <= reqToggle_r;
      reqS2_r <= reqS1_r;
      dinS1_r <= memDataIn;
      dinS2_r <= dinS1_r;
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      st_r <= LS_IDLE;
      bitCnt_r <= '0;
      phase_r <= 1'b0;
      reqSeen_r <= 1'b0;
    end else begin
      phase_r <= rise;
      case (st_r)
        LS_IDLE: begin
          if (newReq) begin
            reqSeen_r <= reqS2_r;
            st_r <= LS_SELECT;
          end
        end
        LS_SELECT: begin
          bitCnt_r <= '0;
          st_r <= LS_CMD;
        end
        LS_CMD: begin
          if (fall) begin
            bitCnt_r <= (bitCnt_r == CMD_LAST) ? '0 : bitCnt_r + 1'b1;
            if (bitCnt_r == CMD_LAST) begin
              st_r <= LS_READ;
            end
          end
        end
        LS_READ: begin
          if (fall) begin
            bitCnt_r <= bitCnt_r + 1'b1;
            if (bitCnt_r == READ_LAST) begin
              st_r <= LS_END;
            end
          end
        end
        LS_END: begin
          st_r <= LS_IDLE;
        end
        default: begin
          st_r <= LS_IDLE;
        end
      endcase
    end
  end

  // command word is always start bit plus the read opcode
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      cmdSh_r <= '0;
    end else if (newReq) begin
      cmdSh_r <= {START_BIT, OPCODE_READ, addrHold_r};
    end else if (st_r == LS_CMD && fall) begin
      cmdSh_r <= {cmdSh_r[CMD_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      pins_r <= PINS_IDLE;
    end else begin
      pins_r.sclk <= rise;
      case (st_r)
        LS_IDLE: begin
          if (newReq) begin
            pins_r.select <= 1'b1;
            pins_r.dataOe <= 1'b1;
            pins_r.dataOut <= 1'b0;
          end
        end
        LS_SELECT: begin
          pins_r.dataOut <= cmdSh_r[CMD_BITS-1];
        end
        LS_CMD: begin
          if (fall && bitCnt_r == CMD_LAST) begin
            pins_r.dataOe <= 1'b0;
            pins_r.dataOut <= 1'b0;
          end else if (fall) begin
            pins_r.dataOut <= cmdSh_r[CMD_BITS-2];
          end
        end
        LS_END: begin
          pins_r.select <= 1'b0;
        end
        default: begin
          pins_r.dataOe <= 1'b0;
        end
      endcase
    end
  end

  // memory answers a rise within one link period; behind the two sync flops
  // that bit is in hand at the fall that follows the next rise, so the first
  // capture is the last address bit, still driven by this block, and the seventeenth is the last data bit
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      dataSh_r <= '0;
      dataHold_r <= '0;
      doneToggle_r <= 1'b0;
    end else begin
      if (st_r == LS_READ && fall) begin
        dataSh_r <= {dataSh_r[DATA_W-2:0], dinS2_r};
      end
      if (st_r == LS_END) begin
        dataHold_r <= dataSh_r;
        doneToggle_r <= !doneToggle_r;
      end
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkRst || !pins_r.select) begin
      riseCnt_r <= '0;
    end else if (rise) begin
      riseCnt_r <= riseCnt_r + 1'b1;
    end
  end

  sequence startBitSeq;
    st_r == LS_CMD && !phase_r && bitCnt_r == '0 && pins_r.dataOut;
  endsequence

  sequence readOpSeq;
    ##2 pins_r.dataOut ##2 !pins_r.dataOut;
  endsequence

  opcode_bits_a: assert property (@(posedge linkClk) disable iff (linkRst)
    startBitSeq |-> readOpSeq)
    else $error("opcode after start bit is not the read code");

  select_first_a: assert property (@(posedge linkClk) disable iff (linkRst)
    $rose(pins_r.select) |-> !pins_r.dataOut ##1 pins_r.dataOut)
    else $error("start bit not preceded by select");

  change_on_fall_a: assert property (@(posedge linkClk) disable iff (linkRst)
    $changed(pins_r.dataOut) && pins_r.select && st_r != LS_CMD |-> $fell(pins_r.sclk))
    else $error("data line changed away from a falling clock");

  addr_on_fall_a: assert property (@(posedge linkClk) disable iff (linkRst)
    st_r == LS_CMD && bitCnt_r > 5'h2 && $changed(pins_r.dataOut) |-> $fell(pins_r.sclk))
    else $error("address bit changed away from a falling clock");

  release_line_a: assert property (@(posedge linkClk) disable iff (linkRst)
    $fell(pins_r.dataOe) |-> riseCnt_r == 6'(CMD_BITS) && !pins_r.sclk)
    else $error("data line released at the wrong bit");

  drive_in_frame_a: assert property (@(posedge linkClk) disable iff (linkRst)
    pins_r.dataOe |-> pins_r.select)
    else $error("data line driven outside a frame");

  deselect_after_a: assert property (@(posedge linkClk) disable iff (linkRst)
    $fell(pins_r.select) |-> $past(riseCnt_r) == FRAME_RISES)
    else $error("select dropped before the last data bit");

  frame_done_a: assert property (@(posedge linkClk) disable iff (linkRst)
    st_r == LS_END |=> !pins_r.select && $changed(doneToggle_r) && dataHold_r == $past(dataSh_r))
    else $error("captured word not handed over at frame end");

endmodule // sewr_word_reader

//--- testbench/sewr_mem_model.sv
`timescale 1ns/1ps
module sewr_mem_model
  import sewr_pkg::*;
(
  // link clock and pins from the reader
  input wire logic linkClk,
  input wire sewr_pkg::sewr_pins_t memPins,
  // answer late, still within one link period
  input wire logic slow,
  // data line level as the reader sees it
  output logic memDataIn,
  // protocol faults seen and frames completed
  output logic [7:0] errCnt,
  output logic [7:0] frames
);
  logic started;
  logic memOe;
  logic memBit;
  logic floatBit;
  logic lastOut;
  logic [9:0] sh;
  logic [DATA_W-1:0] word;
  int cnt;
  int dly;

  initial begin
    {started, memOe, memBit, floatBit, lastOut, sh, word, errCnt, frames} = '0;
    cnt = 0;
    dly = 2;
  end

  // a released line flips every cycle so a stale bit is never read as data
  always @(posedge linkClk) floatBit <= ~floatBit;
  // the reader overrides the memory through the series resistor
  assign memDataIn = memPins.dataOe ? memPins.dataOut : (memOe ? memBit : floatBit);

  // driven bits may only change away from serial clock rises
  always @(posedge linkClk) begin
    #1;
    if (memPins.select && memPins.dataOe && memPins.sclk === 1'b1 && memPins.dataOut !== lastOut) errCnt++;
    lastOut = memPins.dataOut;
  end

  always @(negedge memPins.select) begin
    started = 1'b0;
    cnt = 0;
    memOe <= 1'b0;
  end

  always @(posedge memPins.sclk) begin
    dly = slow ? 24 : 2;
    if (memPins.select === 1'b1) begin
      if (!started) begin
        started = (memDataIn === 1'b1);
      end else begin
        cnt++;
        if (cnt <= 10) sh = {sh[8:0], memDataIn};
        if (cnt >= 11 && memPins.dataOe) errCnt++;
        if (cnt == 10) begin
          if (sh[9:8] !== OPCODE_READ) errCnt++;
          word = {sh[7:0] ^ 8'h5A, ~sh[7:0]};
          memOe <= #(dly) 1'b1;
          memBit <= #(dly) 1'b0;
        end else if (cnt >= 11 && cnt <= 26) begin
          memBit <= #(dly) word[26-cnt];
        end else if (cnt == 27) begin
          frames++;
        end else if (cnt > 27) begin
          // select held past the word: memory would stream on
          errCnt++;
          memBit <= #(dly) ~memBit;
        end
      end
    end
  end
endmodule // sewr_mem_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import sewr_pkg::*;
  localparam int DEPTH = 4;
  localparam int LIMIT = 40000;
  logic clk;
  logic linkClk;
  logic srst;
  logic reqValid;
  logic [ADDR_W-1:0] reqAddr;
  logic reqReady;
  logic wordValid;
  logic [DATA_W-1:0] wordData;
  logic wordReady;
  sewr_pins_t memPins;
  logic memDataIn;
  logic slow;
  logic hold;
  logic stall;
  logic [7:0] errCnt;
  logic [7:0] frames;
  logic [7:0] expFrames;
  logic [DATA_W-1:0] expQ[$];
  int nMismatch;
  int nTests;
  int cyc;
  int taken;
  bit ok;

  sewr_word_reader #(.DEPTH(DEPTH)) dut_u (.clk(clk), .srst(srst), .linkClk(linkClk), .reqValid(reqValid),
    .reqAddr(reqAddr), .reqReady(reqReady), .wordValid(wordValid), .wordData(wordData), .wordReady(wordReady),
    .memPins(memPins), .memDataIn(memDataIn));
  sewr_mem_model mem_u (.linkClk(linkClk), .memPins(memPins), .slow(slow), .memDataIn(memDataIn),
    .errCnt(errCnt), .frames(frames));

  initial begin
    clk = 1'b0;
    linkClk = 1'b0;
    wordReady = 1'b0;
  end
  always #5 clk = ~clk;
  always #16 linkClk = ~linkClk;

  function automatic logic [DATA_W-1:0] expWord(input logic [ADDR_W-1:0] a);
    return {a ^ 8'h5A, ~a};
  endfunction

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want, input string what);
    nTests++;
    if (seen !== want) begin
      nMismatch++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, want);
    end
  endtask

  task automatic testDone;
    $display("checks %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // request held until taken or lim cycles pass; the expected word is noted as it is taken
  task automatic rd(input logic [ADDR_W-1:0] a, input int lim, output bit took);
    int n;
    n = 0;
    took = 1'b0;
    @(negedge clk);
    reqValid = 1'b1;
    reqAddr = a;
    while (!took && n < lim) begin
      @(posedge clk);
      n++;
      if (reqReady === 1'b1) took = 1'b1;
    end
    if (took) begin
      expQ.push_back(expWord(a));
      expFrames++;
    end
  endtask

  task automatic idleDrain;
    int n;
    n = 0;
    @(negedge clk);
    reqValid = 1'b0;
    while ((expQ.size() != 0 || wordValid !== 1'b0) && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check(16'(expQ.size()), 16'h0000, "words missing");
  endtask

  always @(negedge clk) wordReady <= hold ? 1'b0 : (stall ? 1'(($urandom % 3) != 0) : 1'b1);

  always @(posedge clk) begin
    if (srst === 1'b0 && wordValid === 1'b1 && wordReady === 1'b1) begin
      if (expQ.size() == 0) check(16'h0001, 16'h0000, "unexpected word");
      else check(wordData, expQ.pop_front(), "word");
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      nMismatch++;
      testDone();
    end
  end

  initial begin
    {srst, hold} = 2'b11;
    {reqValid, reqAddr, slow, stall, expFrames} = '0;
    void'($urandom(32'h270BAA85));
    // hold reset long enough to reach the link domain
    repeat (12) @(negedge clk);
    srst = 1'b0;
    hold = 1'b0;
    repeat (8) @(negedge clk);
    check(16'(memPins), 16'(PINS_IDLE), "idle pins");
    for (int i = 0; i < 6; i++) begin
      slow = 1'(i);
      rd((i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom), 2000, ok);
      check(16'(ok), 16'h0001, "taken");
    end
    idleDrain();
    $display("test single reads done");
    stall = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'($urandom), 2000, ok);
      check(16'(ok), 16'h0001, "taken");
    end
    idleDrain();
    stall = 1'b0;
    $display("test back to back with stalls done");
    hold = 1'b1;
    taken = 0;
    for (int i = 0; i < DEPTH + 2; i++) begin
      rd(8'($urandom), 600, ok);
      taken += int'(ok);
    end
    check(16'(taken), 16'(DEPTH + 1), "fifo capacity");
    hold = 1'b0;
    idleDrain();
    $display("test fill and drain done");
    rd(8'h3C, 2000, ok);
    @(negedge clk);
    reqValid = 1'b0;
    repeat (80) @(negedge clk);
    srst = 1'b1;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    expQ.delete();
    expFrames--;
    repeat (8) @(negedge clk);
    check(16'(memPins), 16'(PINS_IDLE), "pins after abort");
    rd(8'hC3, 2000, ok);
    idleDrain();
    $display("test reset mid frame done");
    repeat (20) @(negedge clk);
    check(16'(errCnt), 16'h0000, "serial protocol");
    check(16'(frames), 16'(expFrames), "frame count");
    testDone();
  end
endmodule // tb
